/* design/dbsc_code_reg.sv */
// Purpose: register set of one buck: three voltage codes and mode
// Assumes: write strobe already decoded for this buck
// Notes:   range bits load only on i_init
`timescale 1ns/100ps
`include "dbsc_defines.svh"
`default_nettype none

module dbsc_code_reg (
    // clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    // initial load
    input  wire logic                  i_init,
    input  wire logic                  i_range,
    // register access
    input  wire logic                  i_wr_en,
    input  wire logic [1:0]            i_reg_sel,
    input  wire logic [7:0]            i_wr_data,
    output logic      [7:0]            o_rd_data,
    // operating mode and live control
    input  wire dbsc_pkg::dbsc_opmode_e i_op_mode,
    output dbsc_pkg::dbsc_ctrl_s       o_ctrl
);

    logic [2:0] rng_q, rng_d;           // normal, standby, sleep range
    logic [5:0] step_q [3];
    logic [5:0] step_d [3];
    logic [3:0] mode_q, mode_d;

    // next state: range from init only, steps and mode from writes
    always_comb begin
        rng_d  = rng_q;
        step_d = step_q;
        mode_d = mode_q;
        if (i_init) begin
            rng_d = {3{i_range}};
        end
        if (i_wr_en) begin
            if (i_reg_sel == `DBSC_REG_MODE) begin
                mode_d = i_wr_data[`DBSC_MODE_MSB:0];
            end else begin
                // bit 6 of the write is dropped on purpose
                step_d[i_reg_sel] = i_wr_data[`DBSC_STEP_MSB:0];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rng_q  <= 3'h0;
            step_q <= '{3{`DBSC_RST_STEP}};
            mode_q <= `DBSC_RST_MODE;
        end else begin
            rng_q  <= rng_d;
            step_q <= step_d;
            mode_q <= mode_d;
        end
    end

    // read back and mode-dependent code; an unknown mode acts as normal
    always_comb begin
        o_rd_data = 8'h00;
        if (i_reg_sel == `DBSC_REG_MODE) begin
            o_rd_data = {4'h0, mode_q};
        end else begin
            o_rd_data = {1'b0, rng_q[i_reg_sel], step_q[i_reg_sel]};
        end
        o_ctrl.mode = mode_q;
        case (i_op_mode)
            dbsc_pkg::OP_STANDBY: begin
                o_ctrl.range_sel = rng_q[1];
                o_ctrl.step      = step_q[1];
            end
            dbsc_pkg::OP_SLEEP: begin
                o_ctrl.range_sel = rng_q[2];
                o_ctrl.step      = step_q[2];
            end
            default: begin
                o_ctrl.range_sel = rng_q[0];
                o_ctrl.step      = step_q[0];
            end
        endcase
    end

    a_step_pick: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_op_mode == dbsc_pkg::OP_SLEEP |-> o_ctrl.step == step_q[2])
        else $error("sleep step not applied");

    a_init_copy: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_init |=> rng_q == {3{$past(i_range)}})
        else $error("range not copied to all modes");

    a_range_locked: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_wr_en && !i_init |=> $stable(rng_q))
        else $error("range bit changed by write");

    a_mode_write: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_wr_en && i_reg_sel == `DBSC_REG_MODE
        |=> mode_q == $past(i_wr_data[3:0]))
        else $error("mode field not written");

endmodule : dbsc_code_reg
`default_nettype wire

/* design/dbsc_defines.svh */
// Purpose: offsets, field positions, reset values and scale figures
// Assumes: included by bare name from the dual buck set-point design
// Notes:   definitions only
`ifndef DBSC_DEFINES_SVH
`define DBSC_DEFINES_SVH

// register index inside one buck's set; address bit 2 picks the buck
`define DBSC_REG_NORMAL   2'h0
`define DBSC_REG_STANDBY  2'h1
`define DBSC_REG_SLEEP    2'h2
`define DBSC_REG_MODE     2'h3
`define DBSC_BUCK_BIT     2

// field positions of a voltage code register
`define DBSC_RANGE_BIT    6
`define DBSC_STEP_MSB     5
`define DBSC_MODE_MSB     3

// reset values of writable fields
`define DBSC_RST_STEP     6'h20
`define DBSC_RST_MODE     4'h0

// phasing field codes
`define DBSC_PHASE_RSVD   2'h2
`define DBSC_PHASE_INDEP  2'h3

// set point scale in millivolts
`define DBSC_LOW_BASE_MV  12'h190
`define DBSC_LOW_STEP_MV  12'h019
`define DBSC_HIGH_BASE_MV 12'h320
`define DBSC_HIGH_STEP_MV 12'h032

`endif

/* design/dbsc_pkg.sv */
// Purpose: types shared by the dual buck set-point design
// Assumes: nothing
// Notes:   constants live in dbsc_defines.svh
package dbsc_pkg;

    // operating mode of the device power state machine
    typedef enum logic [1:0] {
        OP_NORMAL  = 2'h0,
        OP_STANDBY = 2'h1,
        OP_SLEEP   = 2'h2
    } dbsc_opmode_e;

    // top level sequencing, one-hot
    typedef enum logic [1:0] {
        ST_INIT = 2'b01,
        ST_RUN  = 2'b10
    } dbsc_state_e;

    // live control of one buck
    typedef struct packed {
        logic       range_sel;
        logic [5:0] step;
        logic [3:0] mode;
    } dbsc_ctrl_s;

endpackage : dbsc_pkg

/* design/dbsc_top.sv */
// Purpose: set-point and phasing control of a pair of buck regulators
// Assumes: register port driven by the serial register slave on i_clk_sys
// Notes:   phasing and range are captured once, after reset release
//
// Overview of operation
// - phasing field 00/01 single phase, 11 independent, 10 reserved.
// - single phase regulates from first buck settings and feedback only.
// - independent phasing drives each output from its own register set.
// - range-select bit 6 is fixed by configuration, not by host writes.
// - range zero gives 0.40 V to 1.975 V in 25 mV steps.
// - range one gives 0.800 V to 3.950 V in 50 mV steps.
// - three step values per buck, picked by normal, standby, sleep mode.
// - at init the normal range bit is copied to standby and sleep.
// - in independent phasing each buck's switching mode comes from its four-bit mode field.
// - code 0000000 is 0.4000 V, code 1000000 is 0.8000 V.
`timescale 1ns/100ps
`include "dbsc_defines.svh"
`default_nettype none

module dbsc_top (
    // clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst_n,
    // one-time-programmed configuration
    input  wire logic [1:0]             i_pair_phasing_field,
    input  wire logic                   i_first_buck_range,
    input  wire logic                   i_second_buck_range,
    // register port
    input  wire logic                   i_wr_en,
    input  wire logic                   i_rd_en,
    input  wire logic [2:0]             i_addr,
    input  wire logic [7:0]             i_wr_data,
    output logic      [7:0]             o_rd_data,
    // device operating mode
    input  wire dbsc_pkg::dbsc_opmode_e i_op_mode,
    // feedback comparator pins
    input  wire logic                   i_first_buck_feedback,
    input  wire logic                   i_second_buck_feedback,
    // regulator control
    output dbsc_pkg::dbsc_ctrl_s        o_first_ctrl,
    output dbsc_pkg::dbsc_ctrl_s        o_second_ctrl,
    output logic      [11:0]            o_first_mv,
    output logic      [11:0]            o_second_mv,
    output logic                        o_first_fb,
    output logic                        o_second_fb,
    // configuration status
    output logic                        o_single_phase,
    output logic                        o_cfg_reserved
);

    dbsc_pkg::dbsc_state_e state_q, state_d;
    logic [1:0]            phasing_q, phasing_d;
    logic                  init;
    logic                  single;
    logic                  wr_ok;
    logic [7:0]            rd_first, rd_second;
    dbsc_pkg::dbsc_ctrl_s  ctrl_first, ctrl_second;

    // sequencing: one init cycle after release captures the straps
    always_comb begin
        state_d   = state_q;
        phasing_d = phasing_q;
        init      = 1'b0;
        case (state_q)
            dbsc_pkg::ST_INIT: begin
                init      = 1'b1;
                phasing_d = i_pair_phasing_field;
                state_d   = dbsc_pkg::ST_RUN;
            end
            dbsc_pkg::ST_RUN: begin
                state_d = dbsc_pkg::ST_RUN;
            end
            default: begin
                state_d = dbsc_pkg::ST_INIT;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_q   <= dbsc_pkg::ST_INIT;
            phasing_q <= 2'h0;
        end else begin
            state_q   <= state_d;
            phasing_q <= phasing_d;
        end
    end

    // reserved code falls back to single phase, the safer wiring guess
    assign single = (phasing_q != `DBSC_PHASE_INDEP);
    // writes during init are ignored so the range load cannot race them
    assign wr_ok  = i_wr_en && (state_q == dbsc_pkg::ST_RUN);

    // one register set per buck
    dbsc_code_reg u_first_set (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_init    (init),
        .i_range   (i_first_buck_range),
        .i_wr_en   (wr_ok && !i_addr[`DBSC_BUCK_BIT]),
        .i_reg_sel (i_addr[1:0]),
        .i_wr_data (i_wr_data),
        .o_rd_data (rd_first),
        .i_op_mode (i_op_mode),
        .o_ctrl    (ctrl_first)
    );

    dbsc_code_reg u_second_set (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_init    (init),
        .i_range   (i_second_buck_range),
        .i_wr_en   (wr_ok && i_addr[`DBSC_BUCK_BIT]),
        .i_reg_sel (i_addr[1:0]),
        .i_wr_data (i_wr_data),
        .o_rd_data (rd_second),
        .i_op_mode (i_op_mode),
        .o_ctrl    (ctrl_second)
    );

    // feedback pins: three flops, a change counts once stages 2 and 3 agree
    logic [1:0] fb_s1_q, fb_s2_q, fb_s3_q, fb_filt_q, fb_filt_d;

    always_comb begin
        fb_filt_d = fb_filt_q;
        for (int i = 0; i < 2; i++) begin
            if (fb_s2_q[i] == fb_s3_q[i]) begin
                fb_filt_d[i] = fb_s3_q[i];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            fb_s1_q   <= 2'h0;
            fb_s2_q   <= 2'h0;
            fb_s3_q   <= 2'h0;
            fb_filt_q <= 2'h0;
        end else begin
            fb_s1_q   <= {i_second_buck_feedback, i_first_buck_feedback};
            fb_s2_q   <= fb_s1_q;
            fb_s3_q   <= fb_s2_q;
            fb_filt_q <= fb_filt_d;
        end
    end

    // millivolt target of a code
    function automatic logic [11:0] code_mv(input dbsc_pkg::dbsc_ctrl_s c);
        logic [11:0] s;
        s = {6'h00, c.step};
        if (c.range_sel) begin
            code_mv = `DBSC_HIGH_BASE_MV
                      + 12'(s * `DBSC_HIGH_STEP_MV);
        end else begin
            code_mv = `DBSC_LOW_BASE_MV
                      + 12'(s * `DBSC_LOW_STEP_MV);
        end
    endfunction : code_mv

    // output next values
    dbsc_pkg::dbsc_ctrl_s first_d, second_d;
    logic [11:0]          first_mv_d, second_mv_d;
    logic                 first_fb_d, second_fb_d;
    logic [7:0]           rd_d;

    always_comb begin
        first_d     = ctrl_first;
        second_d    = single ? ctrl_first : ctrl_second;
        first_mv_d  = code_mv(first_d);
        second_mv_d = code_mv(second_d);
        first_fb_d  = fb_filt_q[0];
        // second feedback pin is left open in single phase, so ignore it
        second_fb_d = single ? 1'b0 : fb_filt_q[1];
        rd_d        = o_rd_data;
        if (i_rd_en) begin
            rd_d = i_addr[`DBSC_BUCK_BIT] ? rd_second : rd_first;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_first_ctrl   <= '0;
            o_second_ctrl  <= '0;
            o_first_mv     <= 12'h000;
            o_second_mv    <= 12'h000;
            o_first_fb     <= 1'b0;
            o_second_fb    <= 1'b0;
            o_rd_data      <= 8'h00;
            o_single_phase <= 1'b0;
            o_cfg_reserved <= 1'b0;
        end else begin
            o_first_ctrl   <= first_d;
            o_second_ctrl  <= second_d;
            o_first_mv     <= first_mv_d;
            o_second_mv    <= second_mv_d;
            o_first_fb     <= first_fb_d;
            o_second_fb    <= second_fb_d;
            o_rd_data      <= rd_d;
            o_single_phase <= single && state_q == dbsc_pkg::ST_RUN;
            o_cfg_reserved <= phasing_q == `DBSC_PHASE_RSVD
                              && state_q == dbsc_pkg::ST_RUN;
        end
    end

    // helper: two full cycles spent in run
    logic run_q, run2_q;
    always_ff @(posedge i_clk_sys) begin
        run_q  <= i_rst_n && state_q == dbsc_pkg::ST_RUN;
        run2_q <= i_rst_n && run_q;
    end

    a_phase_decode: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        run_q |-> o_single_phase == (phasing_q != 2'h3))
        else $error("phasing decode wrong");

    a_single_follow: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        run_q && single |=> o_second_ctrl == $past(ctrl_first)
                            && !o_second_fb)
        else $error("second buck not slaved to first");

    a_indep_own: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        run_q && !single |=> o_second_ctrl == $past(ctrl_second))
        else $error("second buck not using own set");

    // straps are static in run, so the output range must match them
    // from the very first cycle that run2_q is high
    a_range_fixed: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        run2_q |-> o_first_ctrl.range_sel == $past(i_first_buck_range, 3))
        else $error("range bit moved after init");

    a_low_mv: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        run2_q && !o_first_ctrl.range_sel |-> o_first_mv ==
            12'(12'd400 + 12'd25 * {6'h00, o_first_ctrl.step}))
        else $error("low range millivolts wrong");

    a_high_mv: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        run2_q && o_second_ctrl.range_sel |-> o_second_mv ==
            12'(12'd800 + 12'd50 * {6'h00, o_second_ctrl.step}))
        else $error("high range millivolts wrong");

endmodule : dbsc_top
`default_nettype wire

/* sim/dbsc_host_model.sv */
// Purpose: host side of the register port of the set-point block
// Assumes: the block samples the port on the rising clock edge
// Notes:   address and data scramble once released
`timescale 1ns/100ps
`default_nettype none

module dbsc_host_model (
    // clock
    input  wire logic       i_clk_sys,
    // register port
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic [2:0]      o_addr,
    output logic [7:0]      o_wr_data,
    input  wire logic [7:0] i_rd_data
);
    // idle port, strobes low
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 3'h5;
        o_wr_data = 8'h5a;
    end

    // legal step for a range; stays above 0.6 V and in the preferred span
    function automatic logic [5:0] pick_step(input logic rg,
                                             input logic [31:0] r);
        return rg ? 6'(24 + r % 27)
                  : 6'(9 + r % 55);
    endfunction : pick_step

    // one access; read data lands one cycle after the read edge
    task automatic access(input logic we, input logic [2:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk_sys);
        #1;
        o_wr_en = we;
        o_rd_en = !we;
        o_addr = a;
        o_wr_data = d;
        @(posedge i_clk_sys);
        #1;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = ~a;
        o_wr_data = ~d;
        @(posedge i_clk_sys);
        #1;
        q = i_rd_data;
    endtask : access

    // in single phase both bucks must hold the same value
    task automatic put_reg(input logic both, input logic bk,
                           input logic [1:0] sel, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, {bk, sel}, d, q);
        if (both)
            access(1'b1, {1'b1, sel}, d, q);
    endtask : put_reg

endmodule : dbsc_host_model
`default_nettype wire

/* sim/dbsc_top_tb.sv */
// Purpose: self-checking bench of the dual buck set-point block
// Assumes: host model drives the register port
// Notes:   straps change only under reset
`timescale 1ns/100ps
`include "dbsc_defines.svh"
`default_nettype none

module dbsc_top_tb;
    // stimulus and observed signals
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic [1:0]             phase = 2'h0;
    logic [1:0]             rng = 2'h0;
    logic                   wr_en, rd_en;
    logic [2:0]             addr;
    logic [7:0]             wr_data, rd_data;
    dbsc_pkg::dbsc_opmode_e op = dbsc_pkg::OP_NORMAL;
    logic [1:0]             fb = 2'h0;
    logic [1:0]             fbo;
    dbsc_pkg::dbsc_ctrl_s   ctrl [2];
    logic [11:0]            mv [2];
    logic                   single, rsvd;
    logic [31:0]            seed = 32'd42902;
    int                     err_total = 0;
    int                     check_count = 0;

    dbsc_top u_dbsc_top (
        .i_clk_sys             (clk),
        .i_rst_n               (rst_n),
        .i_pair_phasing_field  (phase),
        .i_first_buck_range    (rng[0]),
        .i_second_buck_range   (rng[1]),
        .i_wr_en               (wr_en),
        .i_rd_en               (rd_en),
        .i_addr                (addr),
        .i_wr_data             (wr_data),
        .o_rd_data             (rd_data),
        .i_op_mode             (op),
        .i_first_buck_feedback (fb[0]),
        .i_second_buck_feedback(fb[1]),
        .o_first_ctrl          (ctrl[0]),
        .o_second_ctrl         (ctrl[1]),
        .o_first_mv            (mv[0]),
        .o_second_mv           (mv[1]),
        .o_first_fb            (fbo[0]),
        .o_second_fb           (fbo[1]),
        .o_single_phase        (single),
        .o_cfg_reserved        (rsvd)
    );

    dbsc_host_model u_dbsc_host_model (
        .i_clk_sys (clk),
        .o_wr_en   (wr_en),
        .o_rd_en   (rd_en),
        .o_addr    (addr),
        .o_wr_data (wr_data),
        .i_rd_data (rd_data)
    );

    // 250 MHz clock
    always #2 clk = ~clk;

    // xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // target in millivolts for a range and step
    function automatic logic [11:0] exp_mv(input logic r,
                                           input logic [5:0] s);
        return r ? `DBSC_HIGH_BASE_MV + `DBSC_HIGH_STEP_MV * s
                 : `DBSC_LOW_BASE_MV + `DBSC_LOW_STEP_MV * s;
    endfunction : exp_mv

    // value comparison
    task automatic chk_val(input string n, input logic [11:0] e, g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_val

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // reset with new straps; returns just after the first cycle in run, one cycle after init
    task automatic do_reset(input logic [1:0] p, input logic [1:0] r);
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        phase = p;
        rng = r;
        repeat (4) @(posedge clk);
        #1;
        chk_val("mv in reset", 12'h000, mv[0]);
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : do_reset

    // one strap setting: reset contents, writes, readback, live control
    task automatic run_phase(input logic [1:0] p);
        logic       sp;
        logic [1:0] r;
        logic [7:0] q, d;
        logic [5:0] st [2][3];
        logic [3:0] md [2];
        sp = (p != `DBSC_PHASE_INDEP);
        r = 2'(rnd());
        if (sp)
            r = {2{r[0]}};
        do_reset(p, r);
        chk_val("single", 12'(sp), 12'(single));
        chk_val("rsvd", 12'(p == `DBSC_PHASE_RSVD), 12'(rsvd));
        for (int b = 0; b < 2; b++) begin
            md[b] = (sp && b == 1) ? md[0] : 4'(rnd());
            for (int k = 0; k < 3; k++) begin
                u_dbsc_host_model.access(1'b0, {b[0], 2'(k)}, 8'h00, q);
                d = {1'b0, rng[b], `DBSC_RST_STEP};
                chk_val("code reset", 12'(d), 12'(q));
                st[b][k] = (sp && b == 1) ? st[0][k]
                         : u_dbsc_host_model.pick_step(rng[b], rnd());
            end
        end
        // hand-picked edges in two phasings: lowest legal, highest preferred
        if (p == 2'h0 || p == `DBSC_PHASE_INDEP)
            for (int b = 0; b < 2; b++) begin
                st[b][1] = rng[b] ? 6'h18 : 6'h09;
                st[b][2] = rng[b] ? 6'h32 : 6'h3f;
            end
        for (int b = 0; b <= 1 - int'(sp); b++) begin
            for (int k = 0; k < 3; k++)
                u_dbsc_host_model.put_reg(sp, b[0], 2'(k),
                                          {2'(rnd()), st[b][k]});
            u_dbsc_host_model.put_reg(sp, b[0], `DBSC_REG_MODE,
                                      {4'(rnd()), md[b]});
        end
        for (int b = 0; b < 2; b++)
            for (int k = 0; k < 4; k++) begin
                u_dbsc_host_model.access(1'b0, {b[0], 2'(k)}, 8'h00, q);
                d = (k == 3) ? {4'h0, md[b]} : {1'b0, rng[b], st[b][k]};
                chk_val("readback", 12'(d), 12'(q));
            end
        for (int m = 0; m < 4; m++) begin
            op = dbsc_pkg::dbsc_opmode_e'(m);
            fb = 2'(rnd());
            repeat (5) @(posedge clk);
            #1;
            for (int b = 0; b < 2; b++) begin
                d = {1'b0, rng[b], st[b][m % 3]};
                chk_val("ctrl", {d, md[b]}, 12'(ctrl[b]));
                chk_val("mv", exp_mv(d[6], d[5:0]), mv[b]);
            end
            chk_val("fb", {10'h000, fb[1] & !sp, fb[0]}, 12'(fbo));
        end
        $display("phasing %0d range %0d done", p, r);
    endtask : run_phase

    // watchdog
    initial begin
        #80000;
        err_total++;
        final_report();
    end

    // main sequence: every phasing code, twice
    initial begin
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++)
            run_phase(2'(i));
        final_report();
    end

endmodule : dbsc_top_tb
`default_nettype wire
